/* File: core/sfr_bank_regs.vh */
`ifndef SFR_BANK_REGS_VH
`define SFR_BANK_REGS_VH

// Register indexes; byte address on the bus is four times the index
`define SFR_IDX_IE1        6'h00
`define SFR_IDX_IE2        6'h01
`define SFR_IDX_IFG1       6'h02
`define SFR_IDX_IFG2       6'h03
`define SFR_IDX_EVT_STAT   6'h04
`define SFR_IDX_EVT_MASK   6'h05

// Enable byte fields
`define SFR_BIT_WDT_IE     0
`define SFR_BIT_OSC_IE     1
`define SFR_BIT_NMI_IE     4
`define SFR_BIT_ACCV_IE    5
`define SFR_IE1_MASK       8'h33

// Flag byte fields
`define SFR_BIT_WDT_FLAG   0
`define SFR_BIT_OSC_FLAG   1
`define SFR_BIT_POR_FLAG   2
`define SFR_BIT_RST_FLAG   3
`define SFR_BIT_NMI_FLAG   4
`define SFR_IFG1_MASK      8'h1F

// Sticky event status and mask fields
`define SFR_EVT_WDT        0
`define SFR_EVT_OSC        1
`define SFR_EVT_RST        3
`define SFR_EVT_NMI        4
`define SFR_EVT_ACCV       5
`define SFR_EVT_MASK       8'h3B

// Reset values and bus response codes
`define SFR_IE1_RST        8'h00
`define SFR_EVT_RST_VAL    8'h00
`define SFR_RESP_OKAY      2'h0
`define SFR_RESP_SLVERR    2'h2

`endif

/* File: core/sfr_axil_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"

module sfr_axil_port (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        wr_en,
    output wire [5:0]  wr_idx,
    output wire [7:0]  wr_data,
    input  wire        wr_hit,
    output wire [5:0]  rd_idx,
    input  wire [7:0]  rd_data,
    input  wire        rd_hit
);

    reg  [7:0]  awaddr_ff;
    reg  [7:0]  wdata_ff;
    reg         wstrb0_ff;
    wire        do_wr;

    // Both halves held and no answer pending; ready low means held
    assign do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    // Registers are one byte wide, so only lane 0 can change them
    assign wr_en   = do_wr && wstrb0_ff;
    assign wr_idx  = awaddr_ff[7:2];
    assign wr_data = wdata_ff;
    assign rd_idx  = s_axi_araddr[7:2];

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SFR_RESP_OKAY;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 8'h00;
            wstrb0_ff     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff     <= s_axi_wdata[7:0];
                wstrb0_ff    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SFR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata   <= {24'h000000, rd_data};
            s_axi_rresp   <= rd_hit ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // sfr_axil_port

`default_nettype wire

/* File: core/sfr_bank.v */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"

module sfr_bank (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        power_up_clear,
    input  wire        watchdog_event,
    input  wire        watchdog_interval_mode,
    input  wire        osc_fault,
    input  wire        pin_reset_event,
    input  wire        pin_reset_mode,
    input  wire        pin_nonmaskable_event,
    input  wire        flash_access_violation,
    input  wire        global_ie,
    output reg         nonmaskable_req,
    output reg         maskable_req,
    output reg         irq
);

    wire        wr_en;
    wire [5:0]  wr_idx;
    wire [7:0]  wr_data;
    wire [5:0]  rd_idx;
    reg  [7:0]  rd_data;

    reg  [7:0]  ie1_ff;
    reg  [7:0]  nxt_ie1;
    reg         wdt_flag_ff;
    reg         nxt_wdt_flag;
    reg         osc_flag_ff;
    reg         nxt_osc_flag;
    reg         por_flag_ff;
    reg         nxt_por_flag;
    reg         rst_flag_ff;
    reg         nxt_rst_flag;
    reg         nmi_flag_ff;
    reg         nxt_nmi_flag;
    reg  [7:0]  evt_stat_ff;
    reg  [7:0]  nxt_evt_stat;
    reg  [7:0]  evt_mask_ff;
    reg  [7:0]  nxt_evt_mask;
    reg         osc_fault_d_ff;
    reg         accv_d_ff;

    wire [7:0]  ifg1;
    wire [7:0]  evt_set;
    wire        wr_ie1;
    wire        wr_ifg1;
    wire        wr_stat;
    wire        wr_mask;
    wire        pin_reset_hit;
    wire        osc_rise;
    wire        accv_rise;
    wire        nmi_src;
    wire        osc_src;
    wire        accv_src;
    wire        wdt_src;
    wire        evt_pending;

    // Mapped when one of the six word slots; shared by write and read
    function sfr_hit;
        input [5:0] idx;
        begin
            sfr_hit = (idx == `SFR_IDX_IE1) || (idx == `SFR_IDX_IE2) ||
                      (idx == `SFR_IDX_IFG1) || (idx == `SFR_IDX_IFG2) ||
                      (idx == `SFR_IDX_EVT_STAT) ||
                      (idx == `SFR_IDX_EVT_MASK);
        end
    endfunction

    // Write strobe for one register slot
    function wr_sel;
        input       en;
        input [5:0] idx;
        input [5:0] slot;
        begin
            wr_sel = en && (idx == slot);
        end
    endfunction

    // Bus front end; at most one read and two writes in flight, as the write channels reopen while a response waits
    sfr_axil_port u_port (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_idx        (wr_idx),
        .wr_data       (wr_data),
        .wr_hit        (sfr_hit(wr_idx)),
        .rd_idx        (rd_idx),
        .rd_data       (rd_data),
        .rd_hit        (sfr_hit(rd_idx))
    );

    assign wr_ie1  = wr_sel(wr_en, wr_idx, `SFR_IDX_IE1);
    assign wr_ifg1 = wr_sel(wr_en, wr_idx, `SFR_IDX_IFG1);
    assign wr_stat = wr_sel(wr_en, wr_idx, `SFR_IDX_EVT_STAT);
    assign wr_mask = wr_sel(wr_en, wr_idx, `SFR_IDX_EVT_MASK);

    // A pin reset only counts while the shared pin is in reset mode
    assign pin_reset_hit = pin_reset_event && pin_reset_mode;

    assign ifg1 = {3'b000, nmi_flag_ff, rst_flag_ff, por_flag_ff,
                   osc_flag_ff, wdt_flag_ff};

    // Oscillator fault and access violation are levels; count rises,
    // so a source that stays high cannot re-arm a cleared status bit
    assign osc_rise  = osc_fault && !osc_fault_d_ff;
    assign accv_rise = flash_access_violation && !accv_d_ff;
    assign evt_set   = {2'b00,
                        accv_rise,
                        pin_nonmaskable_event,
                        pin_reset_hit,
                        1'b0,
                        osc_rise,
                        watchdog_event};

    // Request terms; the global enable gates only the watchdog term
    assign nmi_src  = nmi_flag_ff && ie1_ff[`SFR_BIT_NMI_IE];
    assign osc_src  = osc_flag_ff && ie1_ff[`SFR_BIT_OSC_IE];
    assign accv_src = flash_access_violation &&
                      ie1_ff[`SFR_BIT_ACCV_IE];
    // Watchdog enable is inert unless the timer is in interval mode
    assign wdt_src  = wdt_flag_ff && ie1_ff[`SFR_BIT_WDT_IE] &&
                      watchdog_interval_mode;
    assign evt_pending = |(evt_stat_ff & evt_mask_ff);

    // Enable byte: plain storage, cleared by power-up clear
    always @* begin
        nxt_ie1 = ie1_ff;
        if (wr_ie1) begin
            nxt_ie1 = wr_data & `SFR_IE1_MASK;
        end
        if (power_up_clear) begin
            nxt_ie1 = `SFR_IE1_RST;
        end
    end

    // Flag byte: in the WDT, OSC, RST and NMI flags the hardware set wins over a write; POR has no hardware set
    always @* begin
        nxt_wdt_flag = wdt_flag_ff;
        nxt_osc_flag = osc_flag_ff;
        nxt_por_flag = por_flag_ff;
        nxt_rst_flag = rst_flag_ff;
        nxt_nmi_flag = nmi_flag_ff;
        // Software writes store the value: one sets a flag, zero clears
        if (wr_ifg1) begin
            nxt_wdt_flag = wr_data[`SFR_BIT_WDT_FLAG];
            nxt_osc_flag = wr_data[`SFR_BIT_OSC_FLAG];
            nxt_por_flag = wr_data[`SFR_BIT_POR_FLAG];
            nxt_rst_flag = wr_data[`SFR_BIT_RST_FLAG];
            nxt_nmi_flag = wr_data[`SFR_BIT_NMI_FLAG];
        end
        // Power-up clear reloads only its own bits, not the cause flags
        if (power_up_clear) begin
            nxt_osc_flag = 1'b1;
            nxt_nmi_flag = 1'b0;
        end
        // Pin reset restarts watchdog tracking
        if (pin_reset_hit) begin
            nxt_wdt_flag = 1'b0;
        end
        if (watchdog_event) begin
            nxt_wdt_flag = 1'b1;
        end
        if (osc_fault) begin
            nxt_osc_flag = 1'b1;
        end
        if (pin_reset_hit) begin
            nxt_rst_flag = 1'b1;
        end
        if (pin_nonmaskable_event) begin
            nxt_nmi_flag = 1'b1;
        end
    end

    // Sticky event status, cleared by writing one; set wins
    always @* begin
        nxt_evt_stat = evt_stat_ff;
        if (wr_stat) begin
            nxt_evt_stat = evt_stat_ff & ~wr_data;
        end
        nxt_evt_stat = (nxt_evt_stat | evt_set) & `SFR_EVT_MASK;
        nxt_evt_mask = evt_mask_ff;
        if (wr_mask) begin
            nxt_evt_mask = wr_data & `SFR_EVT_MASK;
        end
    end

    // Async reset is the power-on reset: it also implies power-up clear
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ie1_ff      <= `SFR_IE1_RST;
            wdt_flag_ff <= 1'b0;
            osc_flag_ff <= 1'b1;
            por_flag_ff <= 1'b1;
            rst_flag_ff <= 1'b0;
            nmi_flag_ff <= 1'b0;
        end else begin
            ie1_ff      <= nxt_ie1;
            wdt_flag_ff <= nxt_wdt_flag;
            osc_flag_ff <= nxt_osc_flag;
            por_flag_ff <= nxt_por_flag;
            rst_flag_ff <= nxt_rst_flag;
            nmi_flag_ff <= nxt_nmi_flag;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_stat_ff <= `SFR_EVT_RST_VAL;
            evt_mask_ff <= `SFR_EVT_RST_VAL;
        end else begin
            evt_stat_ff <= nxt_evt_stat;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    // Delayed copies for rise detection; they reset to the idle level
    // of their sources so that no false edge follows reset
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            osc_fault_d_ff <= 1'b0;
            accv_d_ff      <= 1'b0;
        end else begin
            osc_fault_d_ff <= osc_fault;
            accv_d_ff      <= flash_access_violation;
        end
    end

    // Requests are registered so every output leaves a flip-flop
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nonmaskable_req <= 1'b0;
            maskable_req    <= 1'b0;
            irq             <= 1'b0;
        end else begin
            // Only the individual enables gate these three sources
            nonmaskable_req <= nmi_src || osc_src || accv_src;
            maskable_req    <= wdt_src && global_ie;
            irq             <= evt_pending;
        end
    end

    // Absent bits and the unpopulated second bytes read as zero
    // Reads have no side effect on any flag or status bit
    always @* begin
        case (rd_idx)
            `SFR_IDX_IE1:      rd_data = ie1_ff & `SFR_IE1_MASK;
            `SFR_IDX_IE2:      rd_data = 8'h00;
            `SFR_IDX_IFG1:     rd_data = ifg1 & `SFR_IFG1_MASK;
            `SFR_IDX_IFG2:     rd_data = 8'h00;
            `SFR_IDX_EVT_STAT: rd_data = evt_stat_ff;
            `SFR_IDX_EVT_MASK: rd_data = evt_mask_ff;
            default:           rd_data = 8'h00;
        endcase
    end

endmodule // sfr_bank

`default_nettype wire

/* File: dv/sfr_bank_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module sfr_bank_checker (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        power_up_clear,
    input wire logic        watchdog_interval_mode,
    input wire logic        pin_nonmaskable_event,
    input wire logic        flash_access_violation,
    input wire logic        global_ie,
    input wire logic        nonmaskable_req,
    input wire logic        maskable_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_lat_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("absent bits read nonzero");
    slverr_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    global_gate_a: assert property (
        !global_ie |=> !maskable_req)
        else $error("maskable request without global enable");
    wdt_mode_a: assert property (
        !watchdog_interval_mode |=> !maskable_req)
        else $error("watchdog request outside interval mode");
    // Idle bus and no same-cycle NMI or access violation, so nothing can re-arm a request
    clear_drops_a: assert property (
        power_up_clear && s_axi_awready && !s_axi_awvalid &&
        !pin_nonmaskable_event && !flash_access_violation
        |=> ##1 !nonmaskable_req && !maskable_req)
        else $error("request survives power-up clear");
endmodule // sfr_bank_checker

bind sfr_bank sfr_bank_checker chk_u (.*);

`default_nettype wire

/* File: dv/test_sfr_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"

module test_sfr_bank;
    logic        clk_sys, rstn, power_up_clear, global_ie, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, nonmaskable_req, maskable_req;
    logic        watchdog_interval_mode, pin_reset_mode, osc_fault;
    logic        watchdog_event, pin_reset_event, pin_nonmaskable_event;
    logic        flash_access_violation;
    logic [4:0]  ev;
    int          n_fail, num_checks, k;

    assign {flash_access_violation, pin_nonmaskable_event, pin_reset_event,
            osc_fault, watchdog_event} = ev;

    sfr_bank dut_u (.*);

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang(input int n);
        if (n >= 40) begin
            chk(1'b0, 1'b1);
            end_of_test();
        end
    endtask

    // Response ready is up from the start; bresp is taken at the handshake
    task automatic axw(input logic [5:0] i, input logic [7:0] v,
                       input logic [1:0] er = `SFR_RESP_OKAY);
        int n;
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'($urandom), v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        hang(n);
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] e,
                      input logic [1:0] er = `SFR_RESP_OKAY);
        int n;
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        hang(n);
        chk(s_axi_rdata, {24'h0, e});
        chk(s_axi_rresp, er);
    endtask

    task automatic pulse(input logic [4:0] p);
        ev <= p;
        @(posedge clk_sys);
        ev <= 5'h00;
        repeat (3) @(posedge clk_sys);
    endtask

    function automatic logic [7:0] ebit(input int j);
        case (j)
            0: return 8'h01;
            1: return 8'h02;
            2: return 8'h08;
            3: return 8'h10;
            default: return 8'h20;
        endcase
    endfunction

    initial begin
        {rstn, power_up_clear, global_ie, ev} = '0;
        {watchdog_interval_mode, pin_reset_mode} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        n_fail = 0;
        num_checks = 0;
        void'($urandom(89));
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(`SFR_IDX_IE1, 8'h00);
        rd(`SFR_IDX_IFG1, 8'h06);
        rd(`SFR_IDX_IFG2, 8'h00);
        rd(6'h06, 8'h00, `SFR_RESP_SLVERR);
        axw(6'h06, 8'hFF, `SFR_RESP_SLVERR);
        axw(`SFR_IDX_IE2, 8'hFF);
        rd(`SFR_IDX_IE2, 8'h00);
        for (k = 0; k < 8; k++) begin
            d = (k == 0) ? 8'hFF : 8'($urandom);
            axw(`SFR_IDX_IE1, d);
            rd(`SFR_IDX_IE1, d & `SFR_IE1_MASK);
        end
        // Lane 0 strobe low: the write is answered but changes nothing
        s_axi_wstrb <= 4'h0;
        axw(`SFR_IDX_IE1, 8'h00);
        s_axi_wstrb <= 4'hF;
        rd(`SFR_IDX_IE1, d & `SFR_IE1_MASK);
        axw(`SFR_IDX_IE1, 8'h00);
        axw(`SFR_IDX_EVT_MASK, 8'hFF);
        rd(`SFR_IDX_EVT_MASK, `SFR_EVT_MASK);
        pin_reset_mode <= 1'b1;
        for (k = 0; k < 5; k++) begin
            axw(`SFR_IDX_IFG1, 8'h00);
            axw(`SFR_IDX_EVT_STAT, 8'hFF);
            repeat (2) @(posedge clk_sys);
            chk(irq, 1'b0);
            pulse(5'(1 << k));
            chk(irq, 1'b1);
            rd(`SFR_IDX_IFG1, (k == 4) ? 8'h00 : ebit(k));
            rd(`SFR_IDX_EVT_STAT, ebit(k));
        end
        pin_reset_mode <= 1'b0;
        axw(`SFR_IDX_IFG1, 8'h00);
        pulse(5'h04);
        rd(`SFR_IDX_IFG1, 8'h00);
        axw(`SFR_IDX_IE1, 8'h10);
        pulse(5'h08);
        chk(nonmaskable_req, 1'b1);
        axw(`SFR_IDX_IE1, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk(nonmaskable_req, 1'b0);
        axw(`SFR_IDX_IE1, 8'h02);
        pulse(5'h02);
        chk(nonmaskable_req, 1'b1);
        watchdog_interval_mode <= 1'b1;
        global_ie <= 1'b1;
        axw(`SFR_IDX_IE1, 8'h01);
        pulse(5'h01);
        chk(maskable_req, 1'b1);
        global_ie <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(maskable_req, 1'b0);
        global_ie <= 1'b1;
        watchdog_interval_mode <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(maskable_req, 1'b0);
        watchdog_interval_mode <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(maskable_req, 1'b1);
        axw(`SFR_IDX_IFG1, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk(maskable_req, 1'b0);
        axw(`SFR_IDX_IE1, 8'h33);
        axw(`SFR_IDX_IFG1, 8'h1D);
        power_up_clear <= 1'b1;
        @(posedge clk_sys);
        power_up_clear <= 1'b0;
        @(posedge clk_sys);
        rd(`SFR_IDX_IE1, 8'h00);
        rd(`SFR_IDX_IFG1, 8'h0F);
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(`SFR_IDX_IFG1, 8'h06);
        rd(`SFR_IDX_EVT_MASK, 8'h00);
        end_of_test();
    end
endmodule // test_sfr_bank

`default_nettype wire
